/* File: ift_ctrl.sv */
// I2C master and slave controller with timing settings, address filter and status.
`timescale 1ns/1ns
module ift_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ift_pkg::ift_bus_t bus,
    output logic [ift_pkg::DW-1:0] rd_data,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    logic [ift_pkg::CW-1:0] cfg_div, cfg_to, cfg_setup, cfg_low, cfg_high, cfg_free;
    logic [ift_pkg::DW-1:0] target [ift_pkg::NF];
    logic ovr_sda, ovr_scl;
    logic sda_m, sda_s, sda_q, scl_m, scl_s, scl_q;
    logic [ift_pkg::CW-1:0] smp_cnt, quiet_cnt, free_cnt, m_cnt, s_cnt;
    logic tick, frame, drop_evt, irq_drop;
    logic pend_start, pend_stop, pend_drop, busy;
    logic mst_sda, mst_scl, slv_sda, slv_scl;
    ift_pkg::ift_mst_t mst_st;
    ift_pkg::ift_slv_t slv_st;
    logic [7:0] shreg;
    logic [7:0] next_byte;
    logic [3:0] bit_cnt;
    logic [ift_pkg::NF-1:0] hit, next_hit;
    logic dir;
    logic sda_rise, sda_fall, scl_rise, scl_fall, start_det, stop_det, mst_done;

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        sda_m <= sda_i;
        scl_m <= scl_i;
        sda_q <= sda_s;
        scl_q <= scl_s;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            smp_cnt <= '0;
            sda_s <= 1'b1;
            scl_s <= 1'b1;
        end else if (tick) begin
            smp_cnt <= '0;
            sda_s <= sda_m;
            scl_s <= scl_m;
        end else begin
            smp_cnt <= smp_cnt + 1'b1;
        end
    end
    assign tick = (smp_cnt >= cfg_div);

    // Line events seen on the sampled copies, never on the raw pins.
    assign sda_rise = sda_s && !sda_q;
    assign sda_fall = !sda_s && sda_q;
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_det = sda_fall && scl_s && scl_q;
    assign stop_det = sda_rise && scl_s && scl_q;

    assign drop_evt = frame && !(sda_rise || sda_fall || scl_rise || scl_fall)
                      && (quiet_cnt == cfg_to);

    // Frame tracking and quiet counter; a frame ends on stop, timeout or master drop.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame <= 1'b0;
            quiet_cnt <= '0;
        end else begin
            if (start_det) begin
                frame <= 1'b1;
            end else if (stop_det || drop_evt || (mst_done && pend_drop)) begin
                frame <= 1'b0;
            end
            if (!frame || sda_rise || sda_fall || scl_rise || scl_fall || drop_evt) begin
                quiet_cnt <= '0;
            end else begin
                quiet_cnt <= quiet_cnt + 1'b1;
            end
        end
    end

    // Bus free counter restarts whenever the bus is framed, saturating when idle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            free_cnt <= '0;
        end else if (frame || start_det) begin
            free_cnt <= '0;
        end else if (free_cnt != '1) begin
            free_cnt <= free_cnt + 1'b1;
        end
    end

    // Master sequencer: drop wins over stop, stop over start.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mst_st <= ift_pkg::M_IDLE;
            m_cnt <= '0;
            mst_sda <= 1'b0;
            mst_scl <= 1'b0;
        end else begin
            case (mst_st)
                ift_pkg::M_IDLE: begin
                    m_cnt <= '0;
                    if (pend_drop) begin
                        mst_sda <= 1'b0;
                        mst_scl <= 1'b0;
                    end else if (pend_stop) begin
                        mst_sda <= 1'b1;
                        mst_scl <= 1'b1;
                        mst_st <= ift_pkg::M_SLOW;
                    end else if (pend_start) begin
                        mst_st <= ift_pkg::M_BUF;
                    end
                end
                ift_pkg::M_BUF: begin
                    if (!frame && free_cnt >= cfg_free) begin
                        mst_sda <= 1'b1;
                        mst_st <= ift_pkg::M_START;
                    end
                end
                ift_pkg::M_START: begin
                    if (m_cnt == cfg_high) begin
                        mst_scl <= 1'b1;
                        mst_st <= ift_pkg::M_IDLE;
                    end else begin
                        m_cnt <= m_cnt + 1'b1;
                    end
                end
                ift_pkg::M_SLOW: begin
                    if (m_cnt == cfg_low) begin
                        mst_scl <= 1'b0;
                        m_cnt <= '0;
                        mst_st <= ift_pkg::M_SHIGH;
                    end else begin
                        m_cnt <= m_cnt + 1'b1;
                    end
                end
                // SCL high time, held off while another device stretches
                ift_pkg::M_SHIGH: begin
                    if (m_cnt == cfg_high) begin
                        mst_sda <= 1'b0;
                        mst_st <= ift_pkg::M_IDLE;
                    end else if (scl_s) begin
                        m_cnt <= m_cnt + 1'b1;
                    end
                end
                default: mst_st <= ift_pkg::M_IDLE;
            endcase
        end
    end

    assign mst_done = (mst_st == ift_pkg::M_IDLE && pend_drop)
                      || (mst_st == ift_pkg::M_SHIGH && m_cnt == cfg_high)
                      || (mst_st == ift_pkg::M_START && m_cnt == cfg_high);
    // busy from pending work or a running sequence
    assign busy = pend_start || pend_stop || pend_drop || (mst_st != ift_pkg::M_IDLE);

    // Slave address receiver; the last bit lands in bit seven.
    assign next_byte = {sda_s, shreg[7:1]};
    for (genvar i = 0; i < ift_pkg::NF; i++) begin : g_filter
        assign next_hit[i] = target[i][ift_pkg::TA_EN]
            && (next_byte[ift_pkg::ADDR_BITS-1:0] == target[i][ift_pkg::ADDR_BITS-1:0]);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slv_st <= ift_pkg::S_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            hit <= '0;
            dir <= 1'b0;
            s_cnt <= '0;
            slv_sda <= 1'b0;
            slv_scl <= 1'b0;
        end else if (start_det) begin
            slv_st <= ift_pkg::S_ADDR;
            bit_cnt <= '0;
            hit <= '0;
            slv_sda <= 1'b0;
            slv_scl <= 1'b0;
        end else if (stop_det || drop_evt) begin
            slv_st <= ift_pkg::S_IDLE;
            slv_sda <= 1'b0;
            slv_scl <= 1'b0;
        end else begin
            case (slv_st)
                ift_pkg::S_ADDR: begin
                    if (scl_rise) begin
                        shreg <= next_byte;
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == ift_pkg::LAST_BIT) begin
                            hit <= next_hit;
                            dir <= next_byte[ift_pkg::DIR_BIT];
                            slv_st <= (|next_hit) ? ift_pkg::S_WAITF : ift_pkg::S_DONE;
                        end
                    end
                end
                ift_pkg::S_WAITF: begin
                    if (scl_fall) begin
                        slv_sda <= 1'b1;
                        slv_scl <= 1'b1;
                        s_cnt <= '0;
                        slv_st <= ift_pkg::S_STRETCH;
                    end
                end
                ift_pkg::S_STRETCH: begin
                    if (s_cnt == cfg_setup) begin
                        slv_scl <= 1'b0;
                        slv_st <= ift_pkg::S_ACK;
                    end else begin
                        s_cnt <= s_cnt + 1'b1;
                    end
                end
                ift_pkg::S_ACK: begin
                    if (scl_fall) begin
                        slv_sda <= 1'b0;
                        slv_st <= ift_pkg::S_DONE;
                    end
                end
                ift_pkg::S_IDLE, ift_pkg::S_DONE: slv_st <= slv_st;
                default: slv_st <= ift_pkg::S_IDLE;
            endcase
        end
    end

    // override zero pulls the line low
    assign sda_oe = !ovr_sda || mst_sda || slv_sda;
    assign scl_oe = !ovr_scl || mst_scl || slv_scl;
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    // Register writes; a pending bit set by software stays until its sequence ends.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_div <= ift_pkg::RST_DIV;
            cfg_to <= ift_pkg::RST_TIMEOUT;
            cfg_setup <= ift_pkg::RST_SETUP;
            cfg_low <= ift_pkg::RST_LOW;
            cfg_high <= ift_pkg::RST_HIGH;
            cfg_free <= ift_pkg::RST_FREE;
            target[0] <= '0;
            target[1] <= '0;
            ovr_sda <= 1'b1;
            ovr_scl <= 1'b1;
        end else if (bus.wr) begin
            case (bus.addr)
                ift_pkg::OFF_DIV: cfg_div <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_TIMEOUT: cfg_to <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_SETUP: cfg_setup <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_LOW: cfg_low <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_HIGH: cfg_high <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_FREE: cfg_free <= bus.wdata[ift_pkg::CW-1:0];
                ift_pkg::OFF_TARGET0: target[0] <= bus.wdata;
                ift_pkg::OFF_TARGET1: target[1] <= bus.wdata;
                ift_pkg::OFF_OVERRIDE: begin
                    ovr_sda <= bus.wdata[ift_pkg::OV_SDA];
                    ovr_scl <= bus.wdata[ift_pkg::OV_SCL];
                end
                default: ;
            endcase
        end
    end

    // Pending requests; a new request beats completion of the same kind.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_start <= 1'b0;
            pend_stop <= 1'b0;
            pend_drop <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == ift_pkg::OFF_MASTER && bus.wdata[ift_pkg::MS_DROP]) begin
                pend_drop <= 1'b1;
            end else if (mst_st == ift_pkg::M_IDLE) begin
                pend_drop <= 1'b0;
            end
            if (bus.wr && bus.addr == ift_pkg::OFF_MASTER && bus.wdata[ift_pkg::MS_STOP]) begin
                pend_stop <= 1'b1;
            end else if (mst_st == ift_pkg::M_SHIGH && m_cnt == cfg_high) begin
                pend_stop <= 1'b0;
            end
            if (bus.wr && bus.addr == ift_pkg::OFF_MASTER && bus.wdata[ift_pkg::MS_START]) begin
                pend_start <= 1'b1;
            end else if (mst_st == ift_pkg::M_START && m_cnt == cfg_high) begin
                pend_start <= 1'b0;
            end
        end
    end

    // sticky drop flag, set beats write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_drop <= 1'b0;
        end else if (drop_evt) begin
            irq_drop <= 1'b1;
        end else if (bus.wr && bus.addr == ift_pkg::OFF_IRQ && bus.wdata[ift_pkg::IRQ_DROP]) begin
            irq_drop <= 1'b0;
        end
    end

    // Read data is registered, valid the cycle after the strobe only.
    always_ff @(posedge clk) begin
        if (sys_rst || !bus.rd) begin
            rd_data <= '0;
        end else begin
            rd_data <= '0;
            case (bus.addr)
                ift_pkg::OFF_MASTER: begin
                    rd_data[ift_pkg::MS_BUSY] <= busy;
                    rd_data[ift_pkg::MS_START] <= pend_start;
                    rd_data[ift_pkg::MS_STOP] <= pend_stop;
                    rd_data[ift_pkg::MS_DROP] <= pend_drop;
                end
                ift_pkg::OFF_SLAVE: begin
                    rd_data[ift_pkg::SS_FRAME] <= frame;
                    rd_data[ift_pkg::SS_SDA] <= sda_s;
                    rd_data[ift_pkg::SS_SCL] <= scl_s;
                end
                ift_pkg::OFF_OVERRIDE: begin
                    rd_data[ift_pkg::OV_SDA] <= ovr_sda;
                    rd_data[ift_pkg::OV_SCL] <= ovr_scl;
                end
                ift_pkg::OFF_HIT: rd_data[ift_pkg::NF-1:0] <= hit;
                ift_pkg::OFF_DIR: rd_data[0] <= dir;
                ift_pkg::OFF_IRQ: rd_data[ift_pkg::IRQ_DROP] <= irq_drop;
                ift_pkg::OFF_DIV: rd_data[ift_pkg::CW-1:0] <= cfg_div;
                ift_pkg::OFF_TIMEOUT: rd_data[ift_pkg::CW-1:0] <= cfg_to;
                ift_pkg::OFF_SETUP: rd_data[ift_pkg::CW-1:0] <= cfg_setup;
                ift_pkg::OFF_LOW: rd_data[ift_pkg::CW-1:0] <= cfg_low;
                ift_pkg::OFF_HIGH: rd_data[ift_pkg::CW-1:0] <= cfg_high;
                ift_pkg::OFF_FREE: rd_data[ift_pkg::CW-1:0] <= cfg_free;
                ift_pkg::OFF_TARGET0: rd_data <= target[0];
                ift_pkg::OFF_TARGET1: rd_data <= target[1];
                default: rd_data <= '0;
            endcase
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence stretch_enter_s;
        slv_st == ift_pkg::S_WAITF && scl_fall;
    endsequence
    sequence stretch_end_s;
        slv_st == ift_pkg::S_STRETCH && s_cnt == cfg_setup;
    endsequence

    sample_tick_a: assert property ((tick && cfg_div != '0 && $stable(cfg_div)
        && !(bus.wr && bus.addr == ift_pkg::OFF_DIV)) |=> !tick)
        else $error("sample tick repeats too early");
    drop_timeout_a: assert property (drop_evt |=> !frame && irq_drop)
        else $error("timed out frame not dropped");
    setup_hold_a: assert property (stretch_enter_s |=> slv_scl && slv_sda)
        else $error("stretch not started after data");
    setup_release_a: assert property (stretch_end_s |=> !slv_scl && slv_sda)
        else $error("stretch not released on time");
    low_time_a: assert property ((mst_st == ift_pkg::M_SLOW && m_cnt == cfg_low)
        |=> mst_st == ift_pkg::M_SHIGH && !mst_scl) else $error("low phase wrong length");
    high_time_a: assert property ((mst_st == ift_pkg::M_SHIGH && m_cnt == cfg_high)
        |=> mst_st == ift_pkg::M_IDLE && !mst_sda) else $error("high phase wrong end");
    bus_free_a: assert property ($rose(mst_st == ift_pkg::M_START)
        |-> $past(free_cnt) >= $past(cfg_free)) else $error("start before bus free time");
    hit_enable_a: assert property (hit[0] |-> target[0][ift_pkg::TA_EN] || $changed(target[0]))
        else $error("hit without enabled filter");
    busy_pending_a: assert property ((bus.rd && bus.addr == ift_pkg::OFF_MASTER)
        |=> rd_data[ift_pkg::MS_BUSY] == $past(busy)) else $error("busy bit not reported");
    override_pull_a: assert property ((!ovr_sda |-> sda_oe) and (!ovr_scl |-> scl_oe))
        else $error("override zero did not pull line");
    busy_clear_a: assert property ($fell(busy) |-> $past(mst_done))
        else $error("busy cleared before completion");
endmodule : ift_ctrl

/* File: ift_pkg.sv */
// Shared constants, register map and bus carrier for the I2C timing and filter block.
package ift_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam int unsigned CW = 16;
    localparam int unsigned NF = 2;

    // Register byte offsets.
    localparam logic [AW-1:0] OFF_MASTER = 8'h00;
    localparam logic [AW-1:0] OFF_SLAVE = 8'h04;
    localparam logic [AW-1:0] OFF_OVERRIDE = 8'h08;
    localparam logic [AW-1:0] OFF_HIT = 8'h0C;
    localparam logic [AW-1:0] OFF_DIR = 8'h10;
    localparam logic [AW-1:0] OFF_IRQ = 8'h14;
    localparam logic [AW-1:0] OFF_DIV = 8'h20;
    localparam logic [AW-1:0] OFF_TIMEOUT = 8'h24;
    localparam logic [AW-1:0] OFF_SETUP = 8'h28;
    localparam logic [AW-1:0] OFF_LOW = 8'h2C;
    localparam logic [AW-1:0] OFF_HIGH = 8'h30;
    localparam logic [AW-1:0] OFF_FREE = 8'h34;
    localparam logic [AW-1:0] OFF_TARGET0 = 8'h88;
    localparam logic [AW-1:0] OFF_TARGET1 = 8'h8C;

    // Field positions.
    localparam int unsigned MS_BUSY = 0;
    localparam int unsigned MS_START = 4;
    localparam int unsigned MS_STOP = 5;
    localparam int unsigned MS_DROP = 6;
    localparam int unsigned SS_FRAME = 0;
    localparam int unsigned SS_SDA = 1;
    localparam int unsigned SS_SCL = 2;
    localparam int unsigned OV_SDA = 1;
    localparam int unsigned OV_SCL = 2;
    localparam int unsigned IRQ_DROP = 7;
    localparam int unsigned TA_EN = 15;
    localparam int unsigned ADDR_BITS = 7;
    localparam int unsigned DIR_BIT = 7;

    // Reset values of the timing settings, and the index of the last address bit.
    localparam logic [CW-1:0] RST_DIV = 16'h0000;
    localparam logic [CW-1:0] RST_TIMEOUT = 16'hFFFF;
    localparam logic [CW-1:0] RST_SETUP = 16'h0003;
    localparam logic [CW-1:0] RST_LOW = 16'h0009;
    localparam logic [CW-1:0] RST_HIGH = 16'h0009;
    localparam logic [CW-1:0] RST_FREE = 16'h0009;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } ift_bus_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_BUF = 3'b001,
        M_START = 3'b010,
        M_SLOW = 3'b011,
        M_SHIGH = 3'b100
    } ift_mst_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_WAITF = 3'b010,
        S_STRETCH = 3'b011,
        S_ACK = 3'b100,
        S_DONE = 3'b101
    } ift_slv_t;
endpackage : ift_pkg

/* File: ift_bus_model.sv */
// Behavioural I2C bus master that sends start, one address byte and stop on open-drain lines.
`timescale 1ns/1ns
module ift_bus_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic sda_line,
    input wire logic scl_line,
    output logic sda_pull,
    output logic scl_pull
);
    // Both lines start released, so the pull-ups hold them high.
    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
    end

    // Release SCL and wait until it is really high, since a slave may stretch it.
    task automatic rise_scl();
        int n;
        n = 0;
        @(posedge clk) scl_pull <= 1'b0;
        while (scl_line !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        repeat (HALF) @(posedge clk);
    endtask : rise_scl

    // Start condition: SDA falls while SCL is high, then SCL is pulled.
    task automatic start();
        @(posedge clk) sda_pull <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl_pull <= 1'b1;
    endtask : start

    // Stop condition: SDA rises while SCL is high.
    task automatic stop();
        repeat (HALF) @(posedge clk);
        sda_pull <= 1'b1;
        rise_scl();
        sda_pull <= 1'b0;
    endtask : stop

    // Address byte goes out first bit first into bit 0; the ninth clock leaves SDA to the slave.
    task automatic send(input logic [7:0] b);
        start();
        for (int i = 0; i < 9; i++) begin
            repeat (HALF) @(posedge clk);
            sda_pull <= (i < 8) ? !b[i] : 1'b0;
            rise_scl();
            scl_pull <= 1'b1;
        end
        stop();
    endtask : send
endmodule : ift_bus_model

/* File: ift_ctrl_bench.sv */
// Self-checking bench for the I2C timing, address filter and status block.
`timescale 1ns/1ns
module ift_ctrl_bench;
    localparam logic [15:0] LOW = 16'h0004;
    localparam logic [15:0] HIGH = 16'h0005;
    localparam logic [15:0] FREE = 16'h0014;
    localparam logic [15:0] SETUP = 16'h000B;
    // High time is counted once SCL is seen high, two synchroniser stages after release.
    localparam logic [31:0] SYNC = 32'h2;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    ift_pkg::ift_bus_t bus = '0;
    logic [31:0] rd_data;
    logic sda_o, sda_oe, scl_o, scl_oe, sda_pull, scl_pull, sda_q, scl_q;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & !sda_pull;
    wire scl_w = (scl_oe ? scl_o : 1'b1) & !scl_pull;
    int num_errors = 0;
    int comparisons = 0;
    integer seed = 32'hE320822F;
    logic [63:0] notes[$];
    logic [63:0] nt;
    logic pend = 1'b0;
    logic [7:0] b;
    int sda_age, scl_age, gap_scl, gap_sda, scl_run, sda_run;
    logic [7:0] ra[11] = '{ift_pkg::OFF_DIV, ift_pkg::OFF_TIMEOUT, ift_pkg::OFF_SETUP,
        ift_pkg::OFF_LOW, ift_pkg::OFF_HIGH, ift_pkg::OFF_FREE, ift_pkg::OFF_TARGET0,
        ift_pkg::OFF_TARGET1, ift_pkg::OFF_OVERRIDE, ift_pkg::OFF_MASTER, ift_pkg::OFF_IRQ};
    logic [31:0] rv[11] = '{ift_pkg::RST_DIV, ift_pkg::RST_TIMEOUT, ift_pkg::RST_SETUP,
        ift_pkg::RST_LOW, ift_pkg::RST_HIGH, ift_pkg::RST_FREE, 0, 0, 32'h6, 0, 0};
    logic [7:0] sb[4] = '{8'hAA, 8'h55, 8'h00, 8'hD5};
    logic [1:0] sh[4] = '{2'h1, 2'h2, 2'h0, 2'h0};

    // Free-running system clock.
    initial begin
        forever #5 clk = ~clk;
    end

    ift_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe));
    ift_bus_model pm_u (.clk(clk), .sda_line(sda_w), .scl_line(scl_w),
        .sda_pull(sda_pull), .scl_pull(scl_pull));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '0;
    endtask : wr

    // The expected value is noted now and compared when the data stand.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk) bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        notes.push_back({e & m, m});
        @(posedge clk) bus <= '0;
    endtask : rd

    // Read data are compared at the falling edge, well away from the launching edge.
    always @(negedge clk) begin
        if (pend) begin
            nt = notes.pop_front();
            check("read data", nt[63:32], rd_data & nt[31:0]);
        end
        pend = bus.rd;
    end

    // Ages count edges since each enable last changed; runs keep the previous level length.
    always @(posedge clk) begin
        sda_q <= sda_oe;
        scl_q <= scl_oe;
        sda_age <= (sda_oe !== sda_q) ? 1 : sda_age + 1;
        scl_age <= (scl_oe !== scl_q) ? 1 : scl_age + 1;
        if (sda_oe !== sda_q) begin
            gap_sda <= scl_age;
            sda_run <= sda_age;
        end
        if (scl_oe !== scl_q) begin
            gap_scl <= sda_age;
            scl_run <= scl_age;
        end
    end

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Main sequence: reset values, master sequences, address filter, sampling and timeout.
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i], '1);
        wr(8'h40, $random(seed));
        rd(8'h40, 0, '1);
        wr(ift_pkg::OFF_LOW, LOW);
        wr(ift_pkg::OFF_HIGH, HIGH);
        wr(ift_pkg::OFF_FREE, FREE);
        wr(ift_pkg::OFF_SETUP, SETUP);
        wr(ift_pkg::OFF_MASTER, 32'h10);
        rd(ift_pkg::OFF_MASTER, 32'h11, 32'h71);
        repeat (20) @(posedge clk);
        rd(ift_pkg::OFF_MASTER, 0, 32'h71);
        check("start gap", HIGH + 32'h1, gap_scl);
        wr(ift_pkg::OFF_MASTER, 32'h20);
        rd(ift_pkg::OFF_MASTER, 32'h21, 32'h71);
        repeat (30) @(posedge clk);
        check("stop gap", HIGH + 32'h1 + SYNC, gap_sda);
        check("low phase", 1, scl_run >= LOW + 1);
        // Start right after stop must still wait out the bus free time.
        wr(ift_pkg::OFF_MASTER, 32'h10);
        repeat (40) @(posedge clk);
        check("bus free", 1, sda_run >= FREE);
        wr(ift_pkg::OFF_MASTER, 32'h40);
        repeat (10) @(posedge clk);
        check("drop lines", 0, {sda_oe, scl_oe});
        rd(ift_pkg::OFF_MASTER, 0, 32'h71);
        // A stop from a released bus pulls SCL fresh, so its whole low phase is measured.
        wr(ift_pkg::OFF_MASTER, 32'h20);
        repeat (30) @(posedge clk);
        check("low time", LOW + 32'h1, scl_run);
        check("stop gap idle", HIGH + 32'h1 + SYNC, gap_sda);
        wr(ift_pkg::OFF_TARGET0, 32'h802A);
        wr(ift_pkg::OFF_TARGET1, 32'h8055);
        // Matching, random non-matching and disabled-filter addresses.
        for (int i = 0; i < 4; i++) begin
            b = sb[i];
            if (i == 2) begin
                b = 8'($random(seed));
                if (b[6:0] == 7'h2A || b[6:0] == 7'h55) b[0] = ~b[0];
            end
            if (i == 3) wr(ift_pkg::OFF_TARGET1, 32'h0055);
            pm_u.send(b);
            rd(ift_pkg::OFF_HIT, sh[i], 32'h3);
            if (sh[i] != 0) rd(ift_pkg::OFF_DIR, b[7], 32'h1);
            if (i == 0) check("stretch", SETUP + 32'h1, scl_run);
        end
        // A slow divider must not show a line change before a sample tick.
        wr(ift_pkg::OFF_DIV, 32'd30);
        @(posedge clk) pm_u.scl_pull <= 1'b1;
        rd(ift_pkg::OFF_SLAVE, 32'h6, 32'h6);
        repeat (36) @(posedge clk);
        rd(ift_pkg::OFF_SLAVE, 32'h2, 32'h6);
        @(posedge clk) pm_u.scl_pull <= 1'b0;
        repeat (36) @(posedge clk);
        wr(ift_pkg::OFF_DIV, 0);
        wr(ift_pkg::OFF_TIMEOUT, 32'd40);
        pm_u.start();
        rd(ift_pkg::OFF_SLAVE, 32'h1, 32'h1);
        repeat (60) @(posedge clk);
        rd(ift_pkg::OFF_SLAVE, 0, 32'h1);
        rd(ift_pkg::OFF_IRQ, 32'h80, 32'h80);
        wr(ift_pkg::OFF_IRQ, 32'h80);
        rd(ift_pkg::OFF_IRQ, 0, 32'h80);
        pm_u.stop();
        wr(ift_pkg::OFF_OVERRIDE, 0);
        repeat (2) @(posedge clk);
        check("override pull", 2'b11, {sda_oe, scl_oe});
        wr(ift_pkg::OFF_OVERRIDE, 32'h6);
        repeat (2) @(posedge clk);
        check("override free", 0, {sda_oe, scl_oe});
        repeat (4) @(posedge clk);
        print_verdict();
    end

    // Watchdog well beyond the twelve hundred or so cycles the sequence needs.
    initial begin
        #300000;
        num_errors++;
        print_verdict();
    end
endmodule : ift_ctrl_bench
